/* hdl/cpu_check_regs.svh */
// Named constants for the processor check, display and decode block.
// Assumes inclusion by bare name from the design files only.
`ifndef CPU_CHECK_REGS_SVH
`define CPU_CHECK_REGS_SVH

// ****************************************************************
// Selector switch positions
// ****************************************************************
`define SEL_POS_SAR 3'h1
`define SEL_POS_LSR 3'h2
`define SEL_POS_OPQ 3'h3
`define SEL_POS_B 3'h4
`define SEL_POS_A 3'h5
`define SEL_POS_CS 3'h7

// ****************************************************************
// Operation code fields
// ****************************************************************
`define OP_HI_COMMAND 4'hF
`define OP_PAIR_BOTH 2'h3
`define NIB_TEST_ON 4'h8
`define NIB_TEST_OFF 4'h9
`define NIB_SET_ON 4'hA
`define NIB_SET_OFF 4'hB
`define NIB_EDIT 4'hA
`define NIB_INSERT_TEST 4'hB

// ****************************************************************
// Index register choice and reset values
// ****************************************************************
`define IDX_NONE 2'h0
`define IDX_ONE 2'h1
`define IDX_TWO 2'h2
`define LAMP_RESET 16'h0000
`define BYTE_RESET 8'h00
`define SEL_RESET 3'h0

`endif

/* hdl/cpu_check_pkg.sv */
// Types shared by the processor check, display and decode files.
// Assumes nothing of its surroundings.
package cpu_check_pkg;

  typedef enum logic {
    HALT_RUN,
    HALT_STOPPED
  } halt_state_t;

  typedef enum logic [1:0] {
    FMT_TWO_ADDR,
    FMT_ONE_ADDR,
    FMT_BRANCH,
    FMT_COMMAND
  } op_format_t;

endpackage

/* hdl/lamp_sel_if.sv */
// Carrier between the check block and its lamp multiplexer.
// Assumes both ends run on the same processor clock.
interface lamp_sel_if #(parameter int ADDR_W = 16, parameter int DATA_W = 8);
  logic [2:0] sel;
  logic alu_check;
  logic [ADDR_W-1:0] storage_address_reg;
  logic [ADDR_W-1:0] local_store_regs;
  logic [ADDR_W-1:0] opq;
  logic [ADDR_W-1:0] alu_ctl;
  logic [DATA_W-1:0] b_op;
  logic [DATA_W-1:0] a_op;
  logic [DATA_W-1:0] alu_out;
  logic [DATA_W-1:0] cs_pri;
  logic [ADDR_W-1:0] lamps;

  modport source (
    output sel, alu_check, storage_address_reg, local_store_regs, opq, alu_ctl, b_op, a_op, alu_out, cs_pri,
    input lamps
  );
  modport mux (
    input sel, alu_check, storage_address_reg, local_store_regs, opq, alu_ctl, b_op, a_op, alu_out, cs_pri,
    output lamps
  );
endinterface

/* hdl/lamp_mux.sv */
// Console lamp multiplexer with registered lamp drive.
// Assumes a selector value already settled in the processor clock domain.
`include "cpu_check_regs.svh"

module lamp_mux #(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Sources and selector
  lamp_sel_if.mux bus
);

  if (ADDR_W <= DATA_W) begin : g_bad_width
    $error("lamp_mux needs ADDR_W wider than DATA_W");
  end

  logic [ADDR_W-1:0] lamp_reg;
  logic [ADDR_W-1:0] lamp_next;

  // ****************************************************************
  // Position decode
  // ****************************************************************
  always_comb begin
    case (bus.sel)
      `SEL_POS_SAR: lamp_next = bus.storage_address_reg;
      `SEL_POS_LSR: lamp_next = bus.local_store_regs;
      `SEL_POS_OPQ: lamp_next = bus.opq;
      `SEL_POS_B: begin
        if (bus.alu_check) begin
          lamp_next = bus.alu_ctl;
        end else begin
          lamp_next = {{(ADDR_W-DATA_W){1'b0}}, bus.b_op};
        end
      end
      `SEL_POS_A: begin
        if (bus.alu_check) begin
          lamp_next = {{(ADDR_W-DATA_W){1'b0}}, bus.alu_out};
        end else begin
          lamp_next = {{(ADDR_W-DATA_W){1'b0}}, bus.a_op};
        end
      end
      `SEL_POS_CS: lamp_next = {{(ADDR_W-DATA_W){1'b0}}, bus.cs_pri};
      default: lamp_next = ADDR_W'(`LAMP_RESET);
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      lamp_reg <= ADDR_W'(`LAMP_RESET);
    end else begin
      lamp_reg <= lamp_next;
    end
  end

  assign bus.lamps = lamp_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  a_lamp_sar_shown: assert property (bus.sel == `SEL_POS_SAR |=> bus.lamps == $past(bus.storage_address_reg))
    else $error("lamps do not show storage address");
  a_lamp_a_shown: assert property (bus.sel == `SEL_POS_A && !bus.alu_check
      |=> bus.lamps[DATA_W-1:0] == $past(bus.a_op))
    else $error("lamps do not show A operand");
  a_lamp_alu_ctl: assert property (bus.sel == `SEL_POS_B && bus.alu_check
      |=> bus.lamps == $past(bus.alu_ctl))
    else $error("lamps do not show arithmetic controls");
  a_lamp_cs_pri: assert property (bus.sel == `SEL_POS_CS
      |=> bus.lamps[DATA_W-1:0] == $past(bus.cs_pri))
    else $error("lamps do not show cycle steal priority");
  a_lamp_op_q: assert property (bus.sel == `SEL_POS_OPQ |=> bus.lamps == $past(bus.opq))
    else $error("lamps do not show op and qualifier");

  c_lamp_alu_check: cover property (bus.sel == `SEL_POS_A && bus.alu_check);
  c_lamp_cs: cover property (bus.sel == `SEL_POS_CS);

endmodule

/* hdl/cpu_check_display_and_decode.sv */
// Processor parity stop, console lamp display and instruction group decode.
// Assumes operand inputs come from logic on i_clk; console switches are asynchronous.
`include "cpu_check_regs.svh"

module cpu_check_display_and_decode #(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Operand registers, odd parity per byte
  input wire logic [DATA_W-1:0] i_a_operand,
  input wire logic i_a_parity,
  input wire logic [DATA_W-1:0] i_b_operand,
  input wire logic i_b_parity,
  input wire logic [ADDR_W-1:0] i_storage_address,
  input wire logic [1:0] i_sar_parity,
  // Further display sources
  input wire logic [ADDR_W-1:0] i_local_store,
  input wire logic [ADDR_W-1:0] i_alu_controls,
  input wire logic [DATA_W-1:0] i_alu_output,
  input wire logic [DATA_W-1:0] i_cs_priority,
  // Instruction bytes
  input wire logic i_op_load,
  input wire logic [7:0] i_op_byte,
  input wire logic i_q_load,
  input wire logic [7:0] i_q_byte,
  // Masked test
  input wire logic i_test_strobe,
  input wire logic [7:0] i_storage_byte,
  input wire logic i_test_false_clr,
  // Operand address forming
  input wire logic i_addr_strobe,
  input wire logic i_addr_for_a,
  input wire logic [7:0] i_displacement,
  input wire logic [ADDR_W-1:0] i_direct_address,
  input wire logic [ADDR_W-1:0] i_index_reg_one,
  input wire logic [ADDR_W-1:0] i_index_reg_two,
  // Console switches
  input wire logic [2:0] i_selector,
  input wire logic i_alu_check,
  // Check outputs
  output logic o_halt,
  output logic [2:0] o_parity_source,
  // Lamps
  output logic [ADDR_W-1:0] o_lamp_data,
  // Decode outputs
  output logic [7:0] o_operation_code,
  output logic [7:0] o_qualifier,
  output logic o_set_or_test_off,
  output logic o_test_on_or_off,
  output logic o_edit_instr,
  output logic o_insert_test_chars,
  output logic o_test_false,
  // Address outputs
  output logic [1:0] o_index_select,
  output logic [ADDR_W-1:0] o_operand_address,
  output logic o_address_valid
);

  if (ADDR_W != 2 * DATA_W || DATA_W != 8) begin : g_bad_width
    $error("cpu_check_display_and_decode needs DATA_W 8 and ADDR_W twice DATA_W");
  end

  // ****************************************************************
  // Parity stop
  // ****************************************************************
  cpu_check_pkg::halt_state_t halt_reg, halt_next;
  logic [2:0] src_reg, src_next;
  logic [2:0] parity_err;
  always_comb begin
    parity_err[0] = ~^{i_a_operand, i_a_parity};
    parity_err[1] = ~^{i_b_operand, i_b_parity};
    parity_err[2] = ~^{i_storage_address[ADDR_W-1:DATA_W], i_sar_parity[1]} |
                    ~^{i_storage_address[DATA_W-1:0], i_sar_parity[0]};
    src_next = src_reg | parity_err;
    case (halt_reg)
      cpu_check_pkg::HALT_RUN: halt_next = (|parity_err) ? cpu_check_pkg::HALT_STOPPED : halt_reg;
      cpu_check_pkg::HALT_STOPPED: halt_next = cpu_check_pkg::HALT_STOPPED;
      default: halt_next = cpu_check_pkg::HALT_STOPPED;
    endcase
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      halt_reg <= cpu_check_pkg::HALT_RUN;
      src_reg <= 3'h0;
    end else begin
      halt_reg <= halt_next;
      src_reg <= src_next;
    end
  end

  assign o_halt = (halt_reg == cpu_check_pkg::HALT_STOPPED);
  assign o_parity_source = src_reg;

  // ****************************************************************
  // Console switch synchronisers
  // ****************************************************************
  logic [3:0] sync1_reg, sync2_reg, sync3_reg;
  logic [3:0] console_reg, console_next;
  always_comb begin
    console_next = (sync2_reg == sync3_reg) ? sync3_reg : console_reg;
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      sync3_reg <= 4'h0;
      console_reg <= 4'h0;
    end else begin
      sync1_reg <= {i_alu_check, i_selector};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      console_reg <= console_next;
    end
  end

  // ****************************************************************
  // Operation and qualifier registers with group decode
  // ****************************************************************
  logic [7:0] op_reg, op_next;
  logic [7:0] q_reg, q_next;
  logic [3:0] lines_reg, lines_next;
  logic tbf_reg, tbf_next;
  logic tbn_reg, tbn_next;
  cpu_check_pkg::op_format_t fmt_reg, fmt_next;
  always_comb begin
    op_next = i_op_load ? i_op_byte : op_reg;
    q_next = i_q_load ? i_q_byte : q_reg;
    if (op_next[7:4] == `OP_HI_COMMAND) begin
      fmt_next = cpu_check_pkg::FMT_COMMAND;
    end else if (op_next[5:4] == `OP_PAIR_BOTH) begin
      fmt_next = cpu_check_pkg::FMT_ONE_ADDR;
    end else if (op_next[7:6] == `OP_PAIR_BOTH) begin
      fmt_next = cpu_check_pkg::FMT_BRANCH;
    end else begin
      fmt_next = cpu_check_pkg::FMT_TWO_ADDR;
    end
    tbf_next = (fmt_next == cpu_check_pkg::FMT_ONE_ADDR) && (op_next[3:0] == `NIB_TEST_OFF);
    tbn_next = (fmt_next == cpu_check_pkg::FMT_ONE_ADDR) && (op_next[3:0] == `NIB_TEST_ON);
    lines_next[0] = tbf_next || ((fmt_next == cpu_check_pkg::FMT_ONE_ADDR) &&
                    (op_next[3:0] == `NIB_SET_OFF));
    lines_next[1] = tbf_next || tbn_next;
    lines_next[2] = (fmt_next == cpu_check_pkg::FMT_TWO_ADDR) && (op_next[3:0] == `NIB_EDIT);
    lines_next[3] = (fmt_next == cpu_check_pkg::FMT_TWO_ADDR) && (op_next[3:0] == `NIB_INSERT_TEST);
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      op_reg <= `BYTE_RESET;
      q_reg <= `BYTE_RESET;
      lines_reg <= 4'h0;
      tbf_reg <= 1'b0;
      tbn_reg <= 1'b0;
      fmt_reg <= cpu_check_pkg::FMT_TWO_ADDR;
    end else begin
      op_reg <= op_next;
      q_reg <= q_next;
      lines_reg <= lines_next;
      tbf_reg <= tbf_next;
      tbn_reg <= tbn_next;
      fmt_reg <= fmt_next;
    end
  end

  assign o_operation_code = op_reg;
  assign o_qualifier = q_reg;
  assign o_set_or_test_off = lines_reg[0];
  assign o_test_on_or_off = lines_reg[1];
  assign o_edit_instr = lines_reg[2];
  assign o_insert_test_chars = lines_reg[3];

  // ****************************************************************
  // Test false latch
  // ****************************************************************
  logic tf_reg, tf_next, tf_hit;
  always_comb begin
    tf_hit = i_test_strobe && ((tbf_reg && |(i_storage_byte & q_reg)) ||
             (tbn_reg && |(~i_storage_byte & q_reg)));
    // Set wins over a clear in the same cycle
    tf_next = tf_hit || (tf_reg && !i_test_false_clr);
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      tf_reg <= 1'b0;
    end else begin
      tf_reg <= tf_next;
    end
  end

  assign o_test_false = tf_reg;

  // ****************************************************************
  // Index selection and operand address
  // ****************************************************************
  logic [1:0] idx_sel, idx_reg;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic valid_reg;
  always_comb begin
    case (fmt_reg)
      cpu_check_pkg::FMT_TWO_ADDR: idx_sel = i_addr_for_a ? op_reg[5:4] : op_reg[7:6];
      cpu_check_pkg::FMT_ONE_ADDR: idx_sel = i_addr_for_a ? `IDX_NONE : op_reg[7:6];
      cpu_check_pkg::FMT_BRANCH: idx_sel = i_addr_for_a ? `IDX_NONE : op_reg[5:4];
      default: idx_sel = `IDX_NONE;
    endcase
    case (idx_sel)
      `IDX_ONE: addr_next = ADDR_W'(i_index_reg_one + {{(ADDR_W-8){1'b0}}, i_displacement});
      `IDX_TWO: addr_next = ADDR_W'(i_index_reg_two + {{(ADDR_W-8){1'b0}}, i_displacement});
      default: addr_next = i_direct_address;
    endcase
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      idx_reg <= `IDX_NONE;
      addr_reg <= `LAMP_RESET;
      valid_reg <= 1'b0;
    end else begin
      valid_reg <= i_addr_strobe;
      if (i_addr_strobe) begin
        idx_reg <= idx_sel;
        addr_reg <= addr_next;
      end
    end
  end

  assign o_index_select = idx_reg;
  assign o_operand_address = addr_reg;
  assign o_address_valid = valid_reg;

  // ****************************************************************
  // Lamp display
  // ****************************************************************
  lamp_sel_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) lamp_bus ();
  assign lamp_bus.sel = console_reg[2:0];
  assign lamp_bus.alu_check = console_reg[3];
  assign lamp_bus.storage_address_reg = i_storage_address;
  assign lamp_bus.local_store_regs = i_local_store;
  assign lamp_bus.opq = {op_reg, q_reg};
  assign lamp_bus.alu_ctl = i_alu_controls;
  assign lamp_bus.b_op = i_b_operand;
  assign lamp_bus.a_op = i_a_operand;
  assign lamp_bus.alu_out = i_alu_output;
  assign lamp_bus.cs_pri = i_cs_priority;

  lamp_mux #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_lamp_mux (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .bus(lamp_bus.mux)
  );
  assign o_lamp_data = lamp_bus.lamps;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  a_parity_halts_cpu: assert property (|parity_err |=> o_halt)
    else $error("parity error did not halt");
  a_halt_stays_set: assert property (o_halt |=> o_halt [*8])
    else $error("halt released without reset");
  a_no_spurious_halt: assert property (!o_halt && !(|parity_err) |=> !o_halt)
    else $error("halt without parity error");
  a_test_off_lines: assert property (i_op_load && i_op_byte[5:4] == `OP_PAIR_BOTH &&
      i_op_byte[7:4] != `OP_HI_COMMAND && i_op_byte[3:0] == `NIB_TEST_OFF
      |=> o_set_or_test_off && o_test_on_or_off)
    else $error("test off masked lines missing");
  a_insert_not_edit: assert property (o_insert_test_chars |-> !o_edit_instr)
    else $error("insert test and edit both active");
  a_test_false_set: assert property (tf_hit |=> o_test_false)
    else $error("test false not set");
  a_test_false_ignore: assert property (i_test_strobe && tbf_reg && !(|(i_storage_byte & q_reg)) &&
      !o_test_false |=> !o_test_false)
    else $error("unselected bits set test false");
  a_direct_address: assert property (i_addr_strobe && idx_sel == `IDX_NONE
      |=> o_address_valid && o_operand_address == $past(i_direct_address))
    else $error("unindexed address altered");
  a_index_one_add: assert property (i_addr_strobe && idx_sel == `IDX_ONE
      |=> o_operand_address == ADDR_W'($past(i_index_reg_one) + $past(i_displacement)))
    else $error("index one sum wrong");

  c_halt_rise: cover property (!o_halt ##1 o_halt);
  c_test_false_rise: cover property (!o_test_false ##1 o_test_false);
  c_op_q_shown: cover property (console_reg[2:0] == `SEL_POS_OPQ);

endmodule

/* tb/console_model.sv */
// Console model: selector switch and lamp viewer on the far side of the block.
// Assumes the bench asks for a switch position and reads the lamps through o_lamp_view.
module console_model (
  // Clock
  input wire logic i_clk,
  // Wanted switch settings
  input wire logic [2:0] i_pos,
  input wire logic i_alu_mode,
  // Switch contacts
  output logic [2:0] o_selector,
  output logic o_alu_check,
  // Lamps
  input wire logic [15:0] i_lamps,
  output logic [15:0] o_lamp_view
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_selector = 3'h0;
    o_alu_check = 1'b0;
  end

  // The drum setting reaches the contacts one clock after it is asked for
  always @(posedge i_clk) begin
    o_selector <= i_pos;
    o_alu_check <= i_alu_mode;
  end

  assign o_lamp_view = i_lamps;
endmodule

/* tb/testbench.sv */
// Self-checking bench for the parity stop, lamp display and decode block.
// Assumes a 125 MHz clock and the console model on the selector and lamps.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, rst_b, ap, bp, op_ld, q_ld, ts, tfc, as, afa, alu_mode, alu_check, halt, sto, too, ed, insert_test_chars_op, tf, av;
  logic [7:0] a, b, aluo, csp, op_b, q_b, sb, disp, opc, qual;
  logic [15:0] storage_address_reg, ls, aluc, dir, x1, x2, lamps, lamp_view, oaddr;
  logic [1:0] sarp, isel;
  logic [2:0] pos, sel, psrc;
  int n_mismatch = 0;
  int checks_done = 0;

  cpu_check_display_and_decode u_dut (
    .i_clk(clk), .i_rst_b(rst_b), .i_a_operand(a), .i_a_parity(ap), .i_b_operand(b), .i_b_parity(bp),
    .i_storage_address(storage_address_reg), .i_sar_parity(sarp), .i_local_store(ls), .i_alu_controls(aluc),
    .i_alu_output(aluo), .i_cs_priority(csp), .i_op_load(op_ld), .i_op_byte(op_b), .i_q_load(q_ld),
    .i_q_byte(q_b), .i_test_strobe(ts), .i_storage_byte(sb), .i_test_false_clr(tfc), .i_addr_strobe(as),
    .i_addr_for_a(afa), .i_displacement(disp), .i_direct_address(dir), .i_index_reg_one(x1),
    .i_index_reg_two(x2), .i_selector(sel), .i_alu_check(alu_check), .o_halt(halt), .o_parity_source(psrc),
    .o_lamp_data(lamps), .o_operation_code(opc), .o_qualifier(qual), .o_set_or_test_off(sto),
    .o_test_on_or_off(too), .o_edit_instr(ed), .o_insert_test_chars(insert_test_chars_op), .o_test_false(tf),
    .o_index_select(isel), .o_operand_address(oaddr), .o_address_valid(av)
  );

  console_model u_console (
    .i_clk(clk), .i_pos(pos), .i_alu_mode(alu_mode), .o_selector(sel), .o_alu_check(alu_check),
    .i_lamps(lamps), .o_lamp_view(lamp_view)
  );

  // ****************************************************************
  // Clock, reset and common tasks
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    if (n_mismatch == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic load_op(input logic [7:0] v);
    @(posedge clk);
    op_ld <= 1'b1;
    op_b <= v;
    @(posedge clk);
    op_ld <= 1'b0;
    #1;
  endtask

  task automatic load_q(input logic [7:0] v);
    @(posedge clk);
    q_ld <= 1'b1;
    q_b <= v;
    @(posedge clk);
    q_ld <= 1'b0;
    #1;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_decode();
    logic [7:0] ops [5] = '{8'h39, 8'h0A, 8'h0B, 8'h3B, 8'h38};
    logic [3:0] exp [5] = '{4'hC, 4'h2, 4'h1, 4'h8, 4'h4};
    for (int i = 0; i < 5; i++) begin
      load_op(ops[i]);
      chk("decode lines", {12'h000, exp[i]}, {12'h000, sto, too, ed, insert_test_chars_op});
      chk("op register", {8'h00, ops[i]}, {8'h00, opc});
    end
  endtask

  task automatic strobe(input logic [7:0] v, input logic clr, input logic exp);
    @(posedge clk);
    ts <= 1'b1;
    tfc <= clr;
    sb <= v;
    @(posedge clk);
    ts <= 1'b0;
    tfc <= 1'b0;
    #1;
    chk("test false", {15'h0000, exp}, {15'h0000, tf});
  endtask

  task automatic t_masked();
    load_op(8'h39);
    load_q(8'h0F);
    chk("qualifier", 16'h000F, {8'h00, qual});
    strobe(8'hF0, 1'b0, 1'b0);
    strobe(8'h01, 1'b0, 1'b1);
    strobe(8'h00, 1'b1, 1'b0);
    strobe(8'h02, 1'b1, 1'b1);
    strobe(8'h00, 1'b1, 1'b0);
    load_op(8'h38);
    strobe(8'h0F, 1'b0, 1'b0);
    strobe(8'h0E, 1'b0, 1'b1);
    strobe(8'h0F, 1'b1, 1'b0);
    load_op(8'h3B);
    strobe(8'hFF, 1'b0, 1'b0);
  endtask

  task automatic t_lamp(input logic [2:0] p, input logic m, input logic [15:0] e);
    @(posedge clk);
    pos <= p;
    alu_mode <= m;
    repeat (8) @(posedge clk);
    #1;
    chk("lamps", e, lamp_view);
  endtask

  task automatic t_lamps();
    t_lamp(3'h1, 1'b0, storage_address_reg);
    t_lamp(3'h2, 1'b0, ls);
    t_lamp(3'h3, 1'b0, 16'h3B0F);
    t_lamp(3'h4, 1'b0, {8'h00, b});
    t_lamp(3'h5, 1'b0, {8'h00, a});
    t_lamp(3'h7, 1'b0, {8'h00, csp});
    t_lamp(3'h6, 1'b0, 16'h0000);
    t_lamp(3'h4, 1'b1, aluc);
    t_lamp(3'h5, 1'b1, {8'h00, aluo});
  endtask

  task automatic t_addr(input logic [7:0] op, input logic fa, input logic [1:0] es, input logic [15:0] ea);
    load_op(op);
    @(posedge clk);
    as <= 1'b1;
    afa <= fa;
    @(posedge clk);
    as <= 1'b0;
    #1;
    chk("address valid", 16'h0001, {15'h0000, av});
    chk("index select", {14'h0000, es}, {14'h0000, isel});
    chk("operand address", ea, oaddr);
    @(posedge clk);
    #1;
    chk("address valid", 16'h0000, {15'h0000, av});
  endtask

  task automatic t_parity();
    @(posedge clk);
    ap <= ~ap;
    @(posedge clk);
    ap <= ~ap;
    @(posedge clk);
    #1;
    chk("halt", 16'h0001, {15'h0000, halt});
    chk("parity source", 16'h0001, {13'h0000, psrc});
    @(posedge clk);
    sarp <= sarp ^ 2'h2;
    bp <= ~bp;
    @(posedge clk);
    sarp <= sarp ^ 2'h2;
    bp <= ~bp;
    repeat (10) @(posedge clk);
    #1;
    chk("halt", 16'h0001, {15'h0000, halt});
    chk("parity source", 16'h0007, {13'h0000, psrc});
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    chk("halt", 16'h0000, {15'h0000, halt});
    chk("parity source", 16'h0000, {13'h0000, psrc});
    chk("lamps", 16'h0000, lamp_view);
    @(posedge clk);
    #1;
    chk("halt", 16'h0000, {15'h0000, halt});
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    rst_b = 1'b0;
    a = 8'h5A;
    ap = ~^8'h5A;
    b = 8'hC3;
    bp = ~^8'hC3;
    storage_address_reg = 16'h1234;
    sarp = {~^8'h12, ~^8'h34};
    ls = 16'hBEEF;
    aluc = 16'h0F0F;
    aluo = 8'h77;
    csp = 8'h81;
    {op_ld, q_ld, ts, tfc, as, afa, alu_mode} = 7'h00;
    op_b = 8'h00;
    q_b = 8'h00;
    sb = 8'h00;
    disp = 8'h20;
    dir = 16'h4000;
    x1 = 16'hFFF0;
    x2 = 16'h1000;
    pos = 3'h0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    t_decode();
    t_masked();
    t_lamps();
    t_addr(8'h10, 1'b1, 2'h1, 16'h0010);
    t_addr(8'h80, 1'b0, 2'h2, 16'h1020);
    t_addr(8'h20, 1'b1, 2'h2, 16'h1020);
    t_addr(8'h00, 1'b0, 2'h0, 16'h4000);
    t_addr(8'h73, 1'b0, 2'h1, 16'h0010);
    t_addr(8'h73, 1'b1, 2'h0, 16'h4000);
    t_addr(8'hE0, 1'b0, 2'h2, 16'h1020);
    t_addr(8'hF5, 1'b0, 2'h0, 16'h4000);
    t_parity();
    summarize();
  end

  initial begin
    #50us;
    n_mismatch++;
    summarize();
  end
endmodule
